// ===== inc/irct_pkg.sv
package irct_pkg;
  localparam logic [3:0] IRCT_BANK_NORMAL = 4'h0;
  localparam logic [3:0] IRCT_BANK_TIMER  = 4'hD;
  localparam logic [3:0] IRCT_BANK_SYSTEM = 4'hF;
  localparam logic [3:0] IRCT_OFF_CTL     = 4'h0;
  localparam logic [3:0] IRCT_OFF_T8_LO   = 4'h4;
  localparam logic [3:0] IRCT_OFF_T8_HI   = 4'h5;
  localparam logic [3:0] IRCT_OFF_T16_LO  = 4'h6;
  localparam logic [3:0] IRCT_OFF_T16_HI  = 4'h7;
  localparam logic [3:0] IRCT_OFF_W_CAP_L = 4'h8;
  localparam logic [3:0] IRCT_OFF_W_CAP_H = 4'h9;
  localparam logic [3:0] IRCT_OFF_N_CAP_L = 4'hA;
  localparam logic [3:0] IRCT_OFF_N_CAP_H = 4'hB;
  localparam int IRCT_BIT_RUN     = 7;
  localparam int IRCT_BIT_SINGLE  = 6;
  localparam int IRCT_BIT_TIMEOUT = 5;
  localparam int IRCT_BIT_PRE_HI  = 4;
  localparam int IRCT_BIT_PRE_LO  = 3;
  localparam int IRCT_BIT_CAP_IE  = 2;
  localparam int IRCT_BIT_TO_IE   = 1;
  localparam int IRCT_BIT_PINSEL  = 0;
  localparam logic [7:0] IRCT_RESET_BYTE = 8'h00;
  localparam logic [2:0] IRCT_PRE_RESET  = 3'h0;

  typedef struct packed {
    logic       run;
    logic       single;
    logic       timeout;
    logic [1:0] prescale;
    logic       cap_ie;
    logic       to_ie;
    logic       pin_sel;
  } irct_ctl_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] count;
    logic       level;
  } irct_cap8_t;
endpackage

// ===== src/irct_regs.sv
// Functional notes
// RULE1: Timer registers live in bank D.
// RULE2: Pointer high nibble group, low nibble bank.
// RULE3: Low nibble zero is normal bank.
// RULE4: Only banks 0, F, D exist.
// RULE5: Capture-high holds high-level count, read-only.
// RULE6: Capture-low holds low-level count, read-only.
// RULE7: Wide capture high byte, read-only.
// RULE8: Wide capture low byte, read-only.
// RULE9: Wide reload hold bytes read/write.
// RULE10: Narrow level hold bytes read/write.
// RULE11: Bit 7 starts, stops, reads running.
// RULE12: Modulo-N reloads at terminal count.
// RULE13: Single pass stops at terminal count.
// RULE14: Bit 2 gates capture interrupt.
// RULE15: Flags and masks survive stop recovery.
// RULE16: Timeout set by hardware, cleared writing one.
// RULE17: Bits 4:3 select clock divider.
// RULE18: Bit 1 gates timeout interrupt.
// RULE19: Bit 0 selects pin source.
// RULE20: Interrupt requests are one-cycle pulses.
module irct_regs
  import irct_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        stop_recovery_n,
  input  wire logic [7:0]  bank_group_pointer,
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  input  wire irct_cap8_t  narrow_cap,
  input  wire logic        wide_cap_valid,
  input  wire logic [15:0] wide_cap_value,
  input  wire logic        port_latch_out,
  output logic [7:0]       reg_rdata_ff,
  output logic             reg_hit_ff,
  output logic             shared_output_pin_ff,
  output logic             capture_irq_ff,
  output logic             timeout_irq_ff,
  output logic [15:0]      wide_reload_ff,
  output logic [7:0]       narrow_count_ff
);

  if (CNT_W != 8) begin : g_chk
    $error("irct_regs supports an 8-bit narrow timer only");
  end

  irct_ctl_t  ctl_ff;
  logic [7:0] lo_hold_ff, hi_hold_ff, rl_lo_ff, rl_hi_ff;
  logic [7:0] cap_lo_ff, cap_hi_ff, wcap_lo_ff, wcap_hi_ff;
  logic [2:0] pre_ff;
  logic       level_ff, t8_out_ff;

  // RULE2 group nibble only picks the working group
  wire [3:0] bank_sel = bank_group_pointer[3:0];
  // RULE1 bank D decode
  wire       in_bank  = (bank_sel == IRCT_BANK_TIMER);
  // RULE3 bank 0 leaves normal registers
  wire       normal   = (bank_sel == IRCT_BANK_NORMAL);
  // RULE4 other banks do not answer here
  wire       wr_ok    = reg_wr && in_bank;
  wire       rd_ok    = reg_rd && in_bank;
  wire       wr_ctl   = wr_ok && (reg_addr == IRCT_OFF_CTL);

  function automatic logic pre_tick(input logic [1:0] sel, input logic [2:0] cnt);
    case (sel)
      2'h0:    pre_tick = 1'b1;
      2'h1:    pre_tick = cnt[0];
      2'h2:    pre_tick = &cnt[1:0];
      default: pre_tick = &cnt;
    endcase
  endfunction

  // RULE17 divider select
  wire       tick      = ctl_ff.run && pre_tick(ctl_ff.prescale, pre_ff);
  wire       term      = tick && (narrow_count_ff == 8'h00);
  wire [7:0] reload    = level_ff ? lo_hold_ff : hi_hold_ff;
  // RULE16 hardware set wins over clear
  wire       to_set    = term;
  wire       to_clr    = wr_ctl && reg_wdata[IRCT_BIT_TIMEOUT];
  wire       nxt_to    = to_set ? 1'b1 : (to_clr ? 1'b0 : ctl_ff.timeout);
  // RULE13 single pass drops run at terminal count
  wire       stop_now  = term && ctl_ff.single;

  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      IRCT_OFF_CTL:     rd_mux = ctl_ff;
      IRCT_OFF_T8_LO:   rd_mux = lo_hold_ff;
      IRCT_OFF_T8_HI:   rd_mux = hi_hold_ff;
      IRCT_OFF_T16_LO:  rd_mux = rl_lo_ff;
      IRCT_OFF_T16_HI:  rd_mux = rl_hi_ff;
      IRCT_OFF_W_CAP_L: rd_mux = wcap_lo_ff;
      IRCT_OFF_W_CAP_H: rd_mux = wcap_hi_ff;
      IRCT_OFF_N_CAP_L: rd_mux = cap_lo_ff;
      IRCT_OFF_N_CAP_H: rd_mux = cap_hi_ff;
      default:          rd_mux = IRCT_RESET_BYTE;
    endcase
  end

  // RULE15 stop recovery clears run, pass mode, pin only
  irct_ctl_t nxt_ctl;
  always_comb begin
    nxt_ctl = ctl_ff;
    // RULE11 write wins over auto stop
    if (wr_ctl) begin
      nxt_ctl.run      = reg_wdata[IRCT_BIT_RUN];
      nxt_ctl.single   = reg_wdata[IRCT_BIT_SINGLE];
      nxt_ctl.prescale = reg_wdata[IRCT_BIT_PRE_HI:IRCT_BIT_PRE_LO];
      nxt_ctl.cap_ie   = reg_wdata[IRCT_BIT_CAP_IE];
      nxt_ctl.to_ie    = reg_wdata[IRCT_BIT_TO_IE];
      nxt_ctl.pin_sel  = reg_wdata[IRCT_BIT_PINSEL];
    end else if (stop_now) begin
      nxt_ctl.run = 1'b0;
    end
    nxt_ctl.timeout = nxt_to;
    if (!stop_recovery_n) begin
      nxt_ctl.run     = 1'b0;
      nxt_ctl.single  = 1'b0;
      nxt_ctl.pin_sel = 1'b0;
    end
  end

  // Timeout, prescale and masks clear at power-on, not at stop recovery
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctl_ff <= irct_ctl_t'(IRCT_RESET_BYTE);
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // RULE9 RULE10 hold registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lo_hold_ff <= IRCT_RESET_BYTE;
      hi_hold_ff <= IRCT_RESET_BYTE;
      rl_lo_ff   <= IRCT_RESET_BYTE;
      rl_hi_ff   <= IRCT_RESET_BYTE;
    end else if (wr_ok) begin
      if (reg_addr == IRCT_OFF_T8_LO)  lo_hold_ff <= reg_wdata;
      if (reg_addr == IRCT_OFF_T8_HI)  hi_hold_ff <= reg_wdata;
      if (reg_addr == IRCT_OFF_T16_LO) rl_lo_ff   <= reg_wdata;
      if (reg_addr == IRCT_OFF_T16_HI) rl_hi_ff   <= reg_wdata;
    end
  end

  // RULE5 RULE6 RULE7 RULE8 capture from hardware only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cap_lo_ff  <= IRCT_RESET_BYTE;
      cap_hi_ff  <= IRCT_RESET_BYTE;
      wcap_lo_ff <= IRCT_RESET_BYTE;
      wcap_hi_ff <= IRCT_RESET_BYTE;
    end else begin
      if (narrow_cap.valid && narrow_cap.level)  cap_hi_ff <= narrow_cap.count;
      if (narrow_cap.valid && !narrow_cap.level) cap_lo_ff <= narrow_cap.count;
      if (wide_cap_valid) begin
        wcap_lo_ff <= wide_cap_value[7:0];
        wcap_hi_ff <= wide_cap_value[15:8];
      end
    end
  end

  // RULE12 modulo-N reload from the alternate level hold
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pre_ff          <= IRCT_PRE_RESET;
      narrow_count_ff <= IRCT_RESET_BYTE;
      level_ff        <= 1'b0;
      t8_out_ff       <= 1'b0;
    end else if (!ctl_ff.run) begin
      pre_ff          <= IRCT_PRE_RESET;
      narrow_count_ff <= lo_hold_ff;
      level_ff        <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 3'h1;
      if (term) begin
        narrow_count_ff <= reload;
        level_ff        <= ~level_ff;
        t8_out_ff       <= ~t8_out_ff;
      end else if (tick) begin
        narrow_count_ff <= narrow_count_ff - 8'h01;
      end
    end
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata_ff         <= IRCT_RESET_BYTE;
      reg_hit_ff           <= 1'b0;
      shared_output_pin_ff <= 1'b0;
      capture_irq_ff       <= 1'b0;
      timeout_irq_ff       <= 1'b0;
      wide_reload_ff       <= 16'h0000;
    end else begin
      reg_rdata_ff <= rd_ok ? rd_mux : IRCT_RESET_BYTE;
      reg_hit_ff   <= (rd_ok || wr_ok) && !normal;
      // RULE19 pin source select
      shared_output_pin_ff <= ctl_ff.pin_sel ? t8_out_ff : port_latch_out;
      // RULE14 RULE20 capture pulse
      capture_irq_ff <= narrow_cap.valid && ctl_ff.cap_ie;
      // RULE18 RULE20 timeout pulse
      timeout_irq_ff <= term && ctl_ff.to_ie;
      wide_reload_ff <= {rl_hi_ff, rl_lo_ff};
    end
  end

  property p_ro_cap;
    @(posedge clock) disable iff (!reset_n)
      (wr_ok && reg_addr == IRCT_OFF_N_CAP_H && !narrow_cap.valid) |=> $stable(cap_hi_ff);
  endproperty
  a_ro_cap: assert property (p_ro_cap) else $error("capture high changed by write"); // RULE5

  property p_to_set;
    @(posedge clock) disable iff (!reset_n) term |=> ctl_ff.timeout;
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout not set"); // RULE16

  property p_single;
    @(posedge clock) disable iff (!reset_n || !stop_recovery_n)
      (stop_now && !wr_ctl) |=> !ctl_ff.run;
  endproperty
  a_single: assert property (p_single) else $error("single pass kept running"); // RULE13

  property p_to_irq;
    @(posedge clock) disable iff (!reset_n)
      timeout_irq_ff |-> $past(term) && $past(ctl_ff.to_ie);
  endproperty
  a_to_irq: assert property (p_to_irq) else $error("timeout irq wrong"); // RULE18

  property p_cap_irq;
    @(posedge clock) disable iff (!reset_n)
      (narrow_cap.valid && !ctl_ff.cap_ie) |=> !capture_irq_ff;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq while masked"); // RULE14

  property p_bank;
    @(posedge clock) disable iff (!reset_n) (reg_rd && !in_bank) |=> reg_rdata_ff == 8'h00;
  endproperty
  a_bank: assert property (p_bank) else $error("answer outside bank"); // RULE4

  property p_hold;
    @(posedge clock) disable iff (!reset_n)
      (wr_ok && reg_addr == IRCT_OFF_T16_LO) |=> rl_lo_ff == $past(reg_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("reload hold not written"); // RULE9

  property p_pin;
    @(posedge clock) disable iff (!reset_n)
      !ctl_ff.pin_sel |=> shared_output_pin_ff == $past(port_latch_out);
  endproperty
  a_pin: assert property (p_pin) else $error("pin source wrong"); // RULE19

  property p_ro_cap_lo;
    @(posedge clock) disable iff (!reset_n)
      (wr_ok && reg_addr == IRCT_OFF_N_CAP_L && !narrow_cap.valid) |=> $stable(cap_lo_ff);
  endproperty
  a_ro_cap_lo: assert property (p_ro_cap_lo) else $error("capture low written"); // RULE6

  property p_ro_wcap;
    @(posedge clock) disable iff (!reset_n)
      (wr_ok && reg_addr == IRCT_OFF_W_CAP_H && !wide_cap_valid) |=> $stable(wcap_hi_ff);
  endproperty
  a_ro_wcap: assert property (p_ro_wcap) else $error("wide capture written"); // RULE7

  property p_hold_hi;
    @(posedge clock) disable iff (!reset_n)
      (wr_ok && reg_addr == IRCT_OFF_T8_HI) |=> hi_hold_ff == $past(reg_wdata);
  endproperty
  a_hold_hi: assert property (p_hold_hi) else $error("level hold not written"); // RULE10

  property p_run_wr;
    @(posedge clock) disable iff (!reset_n)
      (wr_ctl && stop_recovery_n) |=> ctl_ff.run == $past(reg_wdata[IRCT_BIT_RUN]);
  endproperty
  a_run_wr: assert property (p_run_wr) else $error("run bit not written"); // RULE11

  property p_modn;
    @(posedge clock) disable iff (!reset_n)
      (term && !ctl_ff.single && !wr_ctl && stop_recovery_n)
        |=> ctl_ff.run && narrow_count_ff == $past(reload);
  endproperty
  a_modn: assert property (p_modn) else $error("modulo reload wrong"); // RULE12

  property p_stop_rec;
    @(posedge clock) disable iff (!reset_n)
      !stop_recovery_n |=> !ctl_ff.run && !ctl_ff.single && !ctl_ff.pin_sel;
  endproperty
  a_stop_rec: assert property (p_stop_rec) else $error("stop recovery kept bits"); // RULE15

  property p_keep;
    @(posedge clock) disable iff (!reset_n)
      (!stop_recovery_n && !wr_ctl) |=> $stable(ctl_ff.prescale) && $stable(ctl_ff.cap_ie)
        && $stable(ctl_ff.to_ie);
  endproperty
  a_keep: assert property (p_keep) else $error("stop recovery lost fields"); // RULE15

  property p_to_clr;
    @(posedge clock) disable iff (!reset_n)
      (to_clr && !term) |=> !ctl_ff.timeout;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("timeout not cleared"); // RULE16

  property p_to_w0;
    @(posedge clock) disable iff (!reset_n)
      (wr_ctl && !reg_wdata[IRCT_BIT_TIMEOUT] && !term) |=> $stable(ctl_ff.timeout);
  endproperty
  a_to_w0: assert property (p_to_w0) else $error("timeout changed by zero"); // RULE16

  property p_cap_on;
    @(posedge clock) disable iff (!reset_n)
      (narrow_cap.valid && ctl_ff.cap_ie) |=> capture_irq_ff;
  endproperty
  a_cap_on: assert property (p_cap_on) else $error("capture irq missing"); // RULE14

  property p_cap_pulse;
    @(posedge clock) disable iff (!reset_n)
      capture_irq_ff |-> $past(narrow_cap.valid) && $past(ctl_ff.cap_ie);
  endproperty
  a_cap_pulse: assert property (p_cap_pulse) else $error("capture irq stray"); // RULE20

  property p_to_pulse;
    @(posedge clock) disable iff (!reset_n)
      (timeout_irq_ff && !term) |=> !timeout_irq_ff;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("timeout irq too long"); // RULE20

  property p_normal;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && normal) |=> !reg_hit_ff && reg_rdata_ff == IRCT_RESET_BYTE;
  endproperty
  a_normal: assert property (p_normal) else $error("bank zero answered"); // RULE3

  property p_pin_t8;
    @(posedge clock) disable iff (!reset_n)
      ctl_ff.pin_sel |=> shared_output_pin_ff == $past(t8_out_ff);
  endproperty
  a_pin_t8: assert property (p_pin_t8) else $error("pin not timer output"); // RULE19

  c_term:  cover property (@(posedge clock) term);
  c_cap:   cover property (@(posedge clock) capture_irq_ff);
  c_clear: cover property (@(posedge clock) to_clr && ctl_ff.timeout);
  c_stop:  cover property (@(posedge clock) !stop_recovery_n && ctl_ff.timeout);
endmodule

// ===== dv/irct_cpu_model.sv
module irct_cpu_model
  import irct_pkg::*;
(
  input  wire logic       clock,
  output logic [7:0]      bank_group_pointer = 8'h00,
  output logic [3:0]      reg_addr = 4'h0,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic [7:0]      reg_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic acc(input logic [3:0] bank, input logic [3:0] off, input logic wr,
                     input logic [7:0] data);
    @(posedge clock);
    bank_group_pointer <= {4'($urandom), bank};
    reg_addr <= off;
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_wdata <= data;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Released bus must not keep old byte
    reg_wdata <= ~data;
  endtask
endmodule

// ===== dv/irct_regs_bench.sv
module irct_regs_bench
  import irct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0, reset_n = 1'b0, stop_recovery_n = 1'b1, rd_late = 1'b0;
  logic        wide_cap_valid = 1'b0, port_latch_out = 1'b0;
  logic        reg_wr, reg_rd, reg_hit_ff, shared_output_pin_ff, capture_irq_ff, timeout_irq_ff;
  logic [3:0]  reg_addr;
  logic [7:0]  bank_group_pointer, reg_wdata, reg_rdata_ff, narrow_count_ff;
  logic [15:0] wide_cap_value = 16'h0000, wide_reload_ff;
  irct_cap8_t  narrow_cap = '0;
  logic [8:0]  exp_q[$], exp_n;
  int          failures = 0, n_compared = 0, cycles = 0;
  irct_regs i_dut (.clock, .reset_n, .stop_recovery_n, .bank_group_pointer, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .narrow_cap, .wide_cap_valid, .wide_cap_value,
    .port_latch_out, .reg_rdata_ff, .reg_hit_ff, .shared_output_pin_ff, .capture_irq_ff,
    .timeout_irq_ff, .wide_reload_ff, .narrow_count_ff);
  irct_cpu_model i_cpu (.clock, .bank_group_pointer, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  always #10 clock = ~clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] off, input logic [7:0] d,
                    input logic [3:0] b = IRCT_BANK_TIMER);
    i_cpu.acc(b, off, 1'b1, d);
  endtask
  task automatic rd(input logic [3:0] off, input logic [7:0] e,
                    input logic [3:0] b = IRCT_BANK_TIMER);
    exp_q.push_back({b == IRCT_BANK_TIMER, e});
    i_cpu.acc(b, off, 1'b0, 8'h00);
  endtask
  // Whole run is a few hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  always @(posedge clock) rd_late <= reg_rd;
  always @(negedge clock) begin
    if (rd_late) begin
      exp_n = exp_q.pop_front();
      check(reg_rdata_ff, exp_n[7:0]);
      check(reg_hit_ff, exp_n[8]);
    end
  end
  task automatic cap(input logic lvl, input logic [7:0] c, input logic ie);
    @(posedge clock);
    narrow_cap <= '{1'b1, c, lvl};
    @(posedge clock);
    narrow_cap <= '{1'b0, ~c, ~lvl};
    @(negedge clock);
    check(capture_irq_ff, ie);
    @(negedge clock);
    check(capture_irq_ff, 1'b0);
  endtask
  task automatic wait_to(output int t, output logic p);
    int n;
    n = 0;
    @(negedge clock);
    while (timeout_irq_ff !== 1'b1 && n < 400) @(negedge clock) n++;
    check(timeout_irq_ff, 1'b1);
    t = cycles;
    p = shared_output_pin_ff;
  endtask
  initial begin
    logic [7:0]  d [4];
    logic [15:0] w;
    logic [7:0]  c;
    logic        p [3];
    int          t [3];
    int          per [4];
    void'($urandom(75101));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(4'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom);
      wr(4'(4 + i), d[i]);
      wr(4'(4 + i), ~d[i], 4'(i * 5));
    end
    for (int i = 0; i < 4; i++) rd(4'(4 + i), d[i]);
    check(wide_reload_ff, {d[3], d[2]});
    rd(4'h4, 8'h00, IRCT_BANK_NORMAL);
    rd(4'h4, 8'h00, IRCT_BANK_SYSTEM);
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, 8'(i << IRCT_BIT_CAP_IE));
      d[0] = 8'($urandom);
      d[1] = 8'($urandom);
      cap(1'b1, d[0], i[0]);
      cap(1'b0, d[1], i[0]);
    end
    w = 16'($urandom);
    @(posedge clock);
    wide_cap_valid <= 1'b1;
    wide_cap_value <= w;
    @(posedge clock);
    wide_cap_valid <= 1'b0;
    wide_cap_value <= ~w;
    for (int i = 8; i < 12; i++) wr(4'(i), 8'($urandom));
    rd(4'h8, w[7:0]);
    rd(4'h9, w[15:8]);
    rd(4'hB, d[0]);
    rd(4'hA, d[1]);
    wr(4'h4, 8'h03);
    wr(4'h5, 8'h03);
    wr(4'h0, 8'hC0);
    repeat (40) @(negedge clock) check(timeout_irq_ff, 1'b0);
    c = narrow_count_ff;
    repeat (8) @(negedge clock);
    check(narrow_count_ff, c);
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h60);
    wr(4'h0, 8'h20);
    rd(4'h0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, 8'(8'h83 | (k << 3)));
      rd(4'h0, 8'(8'h83 | (k << 3)));
      for (int j = 0; j < 3; j++) wait_to(t[j], p[j]);
      per[k] = t[2] - t[1];
      check(16'(per[k]), 16'(4 << k));
      check(p[2], !p[1]);
      wr(4'h0, 8'h20);
    end
    for (int i = 0; i < 4; i++) begin
      c[0] = 1'($urandom);
      @(posedge clock);
      port_latch_out <= c[0];
      @(posedge clock);
      @(negedge clock);
      check(shared_output_pin_ff, c[0]);
    end
    wr(4'h0, 8'hDF);
    repeat (40) @(posedge clock);
    stop_recovery_n <= 1'b0;
    @(posedge clock);
    stop_recovery_n <= 1'b1;
    rd(4'h0, 8'h3E);
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    rd(4'h0, 8'h00);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule
